// *** prescaler_pkg.sv ***
package prescaler_pkg;

  // Counter widths.
  localparam int SYS_PRESCALE_WIDTH = 13;
  localparam int WATCH_PRESCALE_WIDTH = 5;

  // Values after reset and while held.
  localparam logic [12:0] SYS_PRESCALE_RESET = 13'h0000;
  localparam logic [4:0] WATCH_PRESCALE_RESET = 5'h00;

  // Medium-speed input: oscillator clock divided by sixteen.
  localparam int MEDIUM_DIVIDE = 16;
  localparam logic [3:0] MEDIUM_DIV_LAST = 4'(MEDIUM_DIVIDE - 1);
  localparam logic [3:0] MEDIUM_DIV_RESET = 4'h0;

  // Watch clock divided by four feeds the watch prescaler.
  localparam int WATCH_PRE_DIVIDE = 4;
  localparam logic [1:0] WATCH_PRE_DIV_RESET = 2'h0;

  // Clock-select field of the timer A mode register.
  localparam int TIMER_A_SEL_HIGH_POS = 3;
  localparam int TIMER_A_SEL_LOW_POS = 2;

  // Operating modes seen by the prescalers.
  typedef enum logic [2:0] {
    MODE_ACTIVE_HIGH,
    MODE_ACTIVE_MEDIUM,
    MODE_SLEEP,
    MODE_SUBACTIVE,
    MODE_SUBSLEEP,
    MODE_WATCH,
    MODE_STANDBY
  } op_mode_t;

  // Divided taps handed to the peripherals.
  typedef struct packed {
    logic [12:0] sys_div;   // Bit k is system clock divided by 2^(k+1).
    logic [7:0] watch_div;  // Bit 0 watch clock, bit k watch clock / 2^k.
  } prescale_taps_t;

endpackage

// *** prescale_counter.sv ***
`timescale 1ns/1ps
module prescale_counter #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic advance_in,
  input wire logic clear_in,
  // Count
  output logic [WIDTH-1:0] count_out
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // Clear has priority so a held or software-cleared counter never moves.
  assign count_nxt = clear_in ? '0 : (advance_in ? count_r + 1'b1 : count_r);
  assign count_out = count_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

// *** dual_clock_prescalers.sv ***
`timescale 1ns/1ps
// Functional notes
// - The system clock prescaler is a 13-bit binary counter driven by the system clock.
// - In high-speed active and sleep modes the system clock prescaler advances by exactly one per input clock period.
// - Reset clears the system clock prescaler, which counts from the release onward.
// - In standby, watch, subactive and subsleep the system clock prescaler is held at zero.
// - The system clock prescaler has no processor read or write path.
// - In medium-speed active mode it advances once per sixteen oscillator clocks.
// - Its taps are shared by all peripherals, each picking its own ratio.
// - The watch prescaler is a 5-bit counter driven by the watch clock divided by four.
// - Reset clears the watch prescaler, which first advances on the fourth synchronised subclock rising edge after the release.
// - The watch prescaler keeps counting in every low-power mode while the subclock runs.
// - Writing ones to both timer A clock-select bits clears the watch prescaler.
// - The watch prescaler taps serve as the timer A time base.
// - Taps are system clock over 2 to 8192 and watch clock over 1 to 128.
module dual_clock_prescalers
  import prescaler_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Operating mode from the power-mode controller
  input wire prescaler_pkg::op_mode_t op_mode_in,
  // Subclock pin, asynchronous to clk_in
  input wire logic subclock_input_pin_in,
  // Timer A mode register write port
  input wire logic timer_a_mode_write_in,
  input wire logic [7:0] timer_a_mode_data_in,
  // Divided taps and timer A time base
  output prescaler_pkg::prescale_taps_t taps_out,
  output logic [4:0] timer_a_time_base_out,
  output logic watch_tick_out
);

  import prescaler_pkg::*;

  // The subclock pin is slow, so it is sampled and its rising edges act as enables.
  logic sub_meta_r;
  logic sub_sync_r;
  logic sub_prev_r;
  logic [1:0] watch_pre_r;
  logic [1:0] watch_pre_nxt;
  logic [3:0] medium_div_r;
  logic [3:0] medium_div_nxt;
  logic [12:0] sys_count;
  logic [4:0] watch_count;
  logic sys_tap_r;
  logic [12:0] sys_taps_r;
  logic [7:0] watch_taps_r;
  logic [7:0] watch_taps_nxt;

  wire sub_rise = sub_sync_r & ~sub_prev_r;
  wire sys_clock_halted = (op_mode_in == MODE_STANDBY) | (op_mode_in == MODE_WATCH) |
                          (op_mode_in == MODE_SUBACTIVE) | (op_mode_in == MODE_SUBSLEEP);
  wire medium_speed = (op_mode_in == MODE_ACTIVE_MEDIUM);
  wire medium_wrap = (medium_div_r == MEDIUM_DIV_LAST);
  // One advance per system clock, or one per sixteen in medium speed.
  wire sys_advance = medium_speed ? medium_wrap : 1'b1;
  wire watch_advance = sub_rise & (watch_pre_r == 2'(WATCH_PRE_DIVIDE - 1));
  wire watch_clear = timer_a_mode_write_in &
                     timer_a_mode_data_in[TIMER_A_SEL_HIGH_POS] &
                     timer_a_mode_data_in[TIMER_A_SEL_LOW_POS];

  assign watch_pre_nxt = sub_rise ? watch_pre_r + 2'd1 : watch_pre_r;
  assign medium_div_nxt = (!medium_speed || medium_wrap) ? MEDIUM_DIV_RESET :
                          medium_div_r + 4'd1;

  // The watch clock tap itself follows the synchronised subclock, sub_sync_r.
  assign watch_taps_nxt = {watch_count, watch_pre_r[1], watch_pre_r[0], sub_sync_r};

  // No processor port reaches the system prescaler count.
  prescale_counter #(
    .WIDTH(SYS_PRESCALE_WIDTH)
  ) u_sys_prescaler (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .advance_in(sys_advance),
    .clear_in(sys_clock_halted),
    .count_out(sys_count)
  );

  // Watch prescaler ignores the mode so it keeps counting in low power.
  prescale_counter #(
    .WIDTH(WATCH_PRESCALE_WIDTH)
  ) u_watch_prescaler (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .advance_in(watch_advance),
    .clear_in(watch_clear),
    .count_out(watch_count)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sub_meta_r <= 1'b0;
      sub_sync_r <= 1'b0;
      sub_prev_r <= 1'b0;
    end else begin
      sub_meta_r <= subclock_input_pin_in;
      sub_sync_r <= sub_meta_r;
      sub_prev_r <= sub_sync_r;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      watch_pre_r <= WATCH_PRE_DIV_RESET;
      medium_div_r <= MEDIUM_DIV_RESET;
    end else begin
      watch_pre_r <= watch_pre_nxt;
      medium_div_r <= medium_div_nxt;
    end
  end

  // Registered taps keep the outputs glitch free.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_taps_r <= SYS_PRESCALE_RESET;
      watch_taps_r <= 8'h00;
      sys_tap_r <= 1'b0;
    end else begin
      sys_taps_r <= sys_count;
      watch_taps_r <= watch_taps_nxt;
      sys_tap_r <= watch_advance;
    end
  end

  assign taps_out = '{sys_div: sys_taps_r, watch_div: watch_taps_r};
  assign timer_a_time_base_out = watch_taps_r[7:3];
  assign watch_tick_out = sys_tap_r;

endmodule

// *** prescaler_monitor.sv ***
`timescale 1ns/1ps
module prescaler_monitor
  import prescaler_pkg::*;
(
  // Watched ports
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire prescaler_pkg::op_mode_t op_mode_in,
  input wire logic timer_a_mode_write_in,
  input wire logic [7:0] timer_a_mode_data_in,
  input wire prescaler_pkg::prescale_taps_t taps_out,
  input wire logic [4:0] timer_a_time_base_out,
  input wire logic watch_tick_out
);
  // Counts unbroken medium-speed edges, so the rate check never spans a mode change.
  logic [4:0] med_r;
  wire halt_w = op_mode_in inside {MODE_STANDBY, MODE_WATCH, MODE_SUBACTIVE, MODE_SUBSLEEP};
  wire clr_w = timer_a_mode_write_in && timer_a_mode_data_in[3:2] == 2'h3;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      med_r <= 5'h00;
    end else begin
      med_r <= (op_mode_in != MODE_ACTIVE_MEDIUM) ? 5'h00 : med_r + {4'h0, med_r != 5'h1f};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // The taps copy the count one edge late, so a mode seen at an edge shows two edges on.
  sys_step_a: assert property ($past(rst_n_in, 3) && $past(op_mode_in, 2) == MODE_ACTIVE_HIGH
    |-> taps_out.sys_div == $past(taps_out.sys_div) + 13'h0001) else $error("sys step");
  sys_halt_a: assert property ($past(halt_w, 2) |-> taps_out.sys_div == 13'h0000)
    else $error("sys halt");
  med_rate_a: assert property (med_r > 5'h11
    |-> taps_out.sys_div == $past(taps_out.sys_div, 16) + 13'h0001) else $error("medium rate");
  watch_clear_a: assert property (clr_w |-> ##2 timer_a_time_base_out == 5'h00)
    else $error("watch clear");
  // The tick leads the registered time base by one edge, and a clear beats the advance.
  tick_step_a: assert property (watch_tick_out && !clr_w && !$past(clr_w)
    |=> timer_a_time_base_out == $past(timer_a_time_base_out) + 5'h01) else $error("tick step");
  watch_hold_a: assert property (!$past(watch_tick_out) && !$past(clr_w, 2)
    |-> $stable(timer_a_time_base_out)) else $error("watch hold");
  base_copy_a: assert property (taps_out.watch_div[7:3] == timer_a_time_base_out)
    else $error("base copy");
  tick_pulse_a: assert property (watch_tick_out |=> !watch_tick_out)
    else $error("tick pulse");
endmodule
bind dual_clock_prescalers prescaler_monitor u_prescaler_monitor (.clk_in, .rst_n_in,
  .op_mode_in, .timer_a_mode_write_in, .timer_a_mode_data_in, .taps_out,
  .timer_a_time_base_out, .watch_tick_out);

// *** subclock_source.sv ***
`timescale 1ns/1ps
module subclock_source (
  // Subclock pin drive
  output logic subclock_out
);
  // Never paused, since the watch clock is always in use here.
  initial begin
    subclock_out = 1'b0;
    forever #96 subclock_out = ~subclock_out;
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import prescaler_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  op_mode_t mode = MODE_ACTIVE_HIGH;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic sub;
  prescale_taps_t taps;
  logic [4:0] tbase;
  logic [12:0] s;
  int fail_count = 0;
  int num_checks = 0;
  initial forever #4 clk_in = ~clk_in;
  subclock_source u_subclock_source (.subclock_out(sub));
  dual_clock_prescalers u_dual_clock_prescalers (.clk_in, .rst_n_in, .op_mode_in(mode),
    .subclock_input_pin_in(sub), .timer_a_mode_write_in(wr), .timer_a_mode_data_in(wd),
    .taps_out(taps), .timer_a_time_base_out(tbase), .watch_tick_out());
  task chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task t_reset;
    chk("sys in reset", 13'h0000, taps.sys_div);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    cyc(2);
    chk("sys start", 13'h0001, taps.sys_div);
    chk("watch start", 13'h0000, 13'(tbase));
    s = taps.sys_div;
    cyc(100);
    chk("sys step", s + 13'h0064, taps.sys_div);
  endtask
  task t_halt;
    for (int i = 3; i < 7; i++) begin
      @(posedge clk_in);
      mode <= op_mode_t'(3'(i));
      cyc(3);
      chk("sys halted", 13'h0000, taps.sys_div);
      s = 13'(tbase);
      cyc(200);
      chk("watch runs", 13'h0001, 13'(tbase !== s[4:0]));
    end
  endtask
  task t_medium;
    @(posedge clk_in);
    mode <= MODE_ACTIVE_MEDIUM;
    cyc(4);
    s = taps.sys_div;
    cyc(64);
    chk("medium rate", s + 13'h0004, taps.sys_div);
  endtask
  task t_clear;
    @(posedge clk_in);
    wr <= 1'b1;
    wd <= 8'h0c;
    @(posedge clk_in);
    wr <= 1'b0;
    cyc(1);
    chk("watch clear", 13'h0000, 13'(tbase));
  endtask
  initial begin
    cyc(3);
    t_reset();
    t_halt();
    t_medium();
    t_clear();
    results();
  end
  // The run needs about eight microseconds, so this limit only trips on a hang.
  initial begin
    #100us;
    fail_count++;
    results();
  end
endmodule
